// ==== design/tscg_pkg.sv ====
// Constants shared by the two-channel stop capture and gating block
package tscg_pkg;

  // Bus geometry
  localparam int          ADDR_W             = 6;
  localparam int          DATA_W             = 32;

  // Register indices; byte address is four times the index
  localparam int          REG_IDX_EDGE_EN    = 0;
  localparam int          REG_IDX_SW_DIS     = 2;
  localparam int          REG_IDX_CMD        = 4;
  localparam int          REG_IDX_GATE       = 5;
  localparam int          REG_IDX_POWER      = 6;
  localparam int          REG_IDX_RESULT_A   = 8;
  localparam int          REG_IDX_RESULT_B   = 9;
  localparam int          REG_IDX_STATUS     = 10;
  localparam int          REG_IDX_COUNTERS   = 11;

  // Field positions
  localparam int          EDGE_RISE_LSB      = 0;
  localparam int          EDGE_FALL_LSB      = 3;
  localparam int          SW_DIS_W           = 6;
  localparam int          CMD_DELAY_LSB      = 0;
  localparam int          CMD_MASTER_BIT     = 22;
  localparam int          GATE_OFFSET_LSB    = 0;
  localparam int          GATE_STOP_BIT      = 18;
  localparam int          GATE_START_BIT     = 19;
  localparam int          POWER_EN_BIT       = 0;
  localparam int          CNT_B_LSB          = 8;

  // Widths
  localparam int          OFFSET_W           = 18;
  localparam int          TIME_W             = 11;
  localparam int          RESULT_W           = 23;
  localparam int          COUNT_W            = 8;
  localparam int          HIT_DEPTH          = 32;

  // Reset values
  localparam logic [5:0]  EDGE_EN_RST        = 6'h3F;
  localparam logic [5:0]  SW_DIS_RST         = 6'h00;

  // Timing figures and derived cycle counts
  localparam int          CLK_PERIOD_PS      = 20000;
  localparam int          PAIR_BASE_PS       = 5500;
  localparam int          PAIR_STEP_PS       = 1000;
  localparam int          STOP_OPEN_PS       = 7000;
  localparam int          STOP_OPEN_CYCLES   = (STOP_OPEN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          REARM_PS           = 40000;
  localparam int          REARM_CYCLES       = (REARM_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint      RANGE_PS           = 64'd40_000_000;
  localparam int          RANGE_CYCLES       = int'(RANGE_PS / CLK_PERIOD_PS);
  localparam int          VALID_PS           = 107000;
  localparam int          VALID_CYCLES       = VALID_PS / CLK_PERIOD_PS;

endpackage

// ==== design/tscg_hit_fifo.sv ====
// Hit result buffer held in flip-flops, with clear, full and empty
module tscg_hit_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             clear_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic      [WIDTH-1:0] head_o,
  output logic                  empty_o,
  output logic                  full_o
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             do_push;
  logic             do_pop;

  assign do_push = push_i && !full_o;
  assign do_pop  = pop_i && !empty_o;
  assign head_o  = mem[rd_ptr];

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  always_ff @(posedge ref_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointers and flags
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || clear_i) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      count   <= '0;
      empty_o <= 1'b1;
      full_o  <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count   <= count + 1'b1;
        empty_o <= 1'b0;
        full_o  <= (count == (PW+1)'(DEPTH - 1));
      end else if (do_pop && !do_push) begin
        count   <= count - 1'b1;
        empty_o <= (count == (PW+1)'(1));
        full_o  <= 1'b0;
      end
    end
  end

endmodule

// ==== design/tscg_stop_capture.sv ====
// Two-channel stop capture with input gating, counters and result buffers
module tscg_stop_capture
  import tscg_pkg::*;
#(
  parameter int HIT_DEPTH_P = tscg_pkg::HIT_DEPTH
) (
  input  wire logic                        ref_clk_i,
  input  wire logic                        rst_b_i,
  input  wire logic [tscg_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                        avs_read_i,
  input  wire logic                        avs_write_i,
  input  wire logic [tscg_pkg::DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                  avs_byteenable_i,
  output logic      [tscg_pkg::DATA_W-1:0] avs_readdata_o,
  output logic                             avs_waitrequest_o,
  input  wire logic                        start_i,
  input  wire logic                        stop_input_one_i,
  input  wire logic                        stop_input_two_i,
  input  wire logic                        start_hw_disable_i,
  input  wire logic [3:0]                  stop_hw_disable_pin_i,
  output logic      [1:0]                  result_buffer_empty_flag_o,
  output logic                             diff_input_power_enable_o
);

  import tscg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [3:0]        be);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [1:0] pair_holdoff(input logic [1:0] sel);
    int ps;
    ps = PAIR_BASE_PS + PAIR_STEP_PS * int'(sel);
    return 2'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS - 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [5:0]          edge_en;
  logic [5:0]          sw_dis;
  logic [1:0]          edge_delay_select;
  logic [OFFSET_W-1:0] start_offset;
  logic                stop_gate_until_start;
  logic                start_close_after_first;
  logic [3:0]          reg_idx;
  logic                access;
  logic                wr_en;
  logic                rd_en;
  logic [DATA_W-1:0]   wmerged;
  logic [DATA_W-1:0]   edge_en_wr;
  logic [DATA_W-1:0]   sw_dis_wr;
  logic                mrst;
  logic [1:0]          rearm_cnt;
  logic                inputs_open;
  logic [2:0]          in_prev;
  logic [2:0]          in_now;
  logic [2:0]          rise;
  logic [2:0]          fall;
  logic                start_seen;
  logic                start_acc;
  logic [1:0]          open_cnt;
  logic                stop_window;
  logic [TIME_W-1:0]   time_cnt;
  logic                over_range;
  logic [3:0]          stop_edge;
  logic [3:0]          path_en;
  logic [3:0]          path_dis;
  logic [1:0]          holdoff [4];
  logic [3:0]          stop_acc;
  logic [COUNT_W-1:0]  stop_hit_counter_a;
  logic [COUNT_W-1:0]  stop_hit_counter_b;
  logic [RESULT_W-1:0] result_word;
  logic [1:0]          push;
  logic [1:0]          pop;
  logic [RESULT_W-1:0] head [2];
  logic [1:0]          fifo_empty;
  logic [1:0]          fifo_full;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave decode: one wait cycle then a single ready cycle
  assign reg_idx = avs_address_i[ADDR_W-1:2];
  assign access  = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign wr_en   = access && avs_write_i;
  assign rd_en   = access && avs_read_i;
  assign wmerged    = be_merge('0, avs_writedata_i, avs_byteenable_i);
  assign edge_en_wr = be_merge(DATA_W'(edge_en), avs_writedata_i, avs_byteenable_i);
  assign sw_dis_wr  = be_merge(DATA_W'(sw_dis), avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, untouched by master reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      edge_en                   <= EDGE_EN_RST;
      sw_dis                    <= SW_DIS_RST;
      edge_delay_select         <= '0;
      start_offset              <= '0;
      stop_gate_until_start     <= 1'b0;
      start_close_after_first   <= 1'b0;
      diff_input_power_enable_o <= 1'b0;
    end else if (wr_en) begin
      unique case (int'(reg_idx))
        REG_IDX_EDGE_EN: begin
          edge_en <= edge_en_wr[5:0];
        end
        REG_IDX_SW_DIS: begin
          sw_dis <= sw_dis_wr[SW_DIS_W-1:0];
        end
        REG_IDX_CMD: begin
          if (avs_byteenable_i[0]) begin
            edge_delay_select <= avs_writedata_i[CMD_DELAY_LSB +: 2];
          end
        end
        REG_IDX_GATE: begin
          if (avs_byteenable_i[0]) begin
            start_offset[7:0] <= avs_writedata_i[7:0];
          end
          if (avs_byteenable_i[1]) begin
            start_offset[15:8] <= avs_writedata_i[15:8];
          end
          if (avs_byteenable_i[2]) begin
            start_offset[OFFSET_W-1:16]  <= avs_writedata_i[OFFSET_W-1:16];
            stop_gate_until_start   <= avs_writedata_i[GATE_STOP_BIT];
            start_close_after_first <= avs_writedata_i[GATE_START_BIT];
          end
        end
        REG_IDX_POWER: begin
          if (avs_byteenable_i[0]) begin
            diff_input_power_enable_o <= avs_writedata_i[POWER_EN_BIT];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master reset and re-arm delay
  // Master reset command
  assign mrst        = wr_en && (int'(reg_idx) == REG_IDX_CMD) && wmerged[CMD_MASTER_BIT];
  assign inputs_open = (rearm_cnt == '0);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      rearm_cnt <= '0;
    end else if (mrst) begin
      rearm_cnt <= 2'(REARM_CYCLES);
    end else if (!inputs_open) begin
      rearm_cnt <= rearm_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on start and both stop inputs
  assign in_now = {stop_input_two_i, stop_input_one_i, start_i};
  assign rise   = in_now & ~in_prev;
  assign fall   = ~in_now & in_prev;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      in_prev <= '0;
    end else begin
      in_prev <= in_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start acceptance and start gating
  // Start accept gating
  assign start_acc = inputs_open && diff_input_power_enable_o && !start_hw_disable_i
                     && ((rise[0] && edge_en[EDGE_RISE_LSB])
                         || (fall[0] && edge_en[EDGE_FALL_LSB]))
                     && !(start_close_after_first && start_seen);

  assign stop_window = !stop_gate_until_start || (start_seen && (open_cnt == '0));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || mrst) begin
      start_seen <= 1'b0;
      open_cnt   <= '0;
    end else if (start_acc) begin
      start_seen <= 1'b1;
      open_cnt   <= 2'(STOP_OPEN_CYCLES - 1);
    end else if (open_cnt != '0) begin
      open_cnt <= open_cnt - 1'b1;
    end
  end

  assign over_range = (time_cnt == TIME_W'(RANGE_CYCLES));

  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || mrst) begin
      time_cnt <= '0;
    end else if (start_acc) begin
      time_cnt <= '0;
    end else if (start_seen && !over_range) begin
      time_cnt <= time_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop path gating: 0 one-rise, 1 one-fall, 2 two-rise, 3 two-fall
  assign stop_edge = {fall[2], rise[2], fall[1], rise[1]};
  assign path_en   = {edge_en[EDGE_FALL_LSB+2], edge_en[EDGE_RISE_LSB+2],
                      edge_en[EDGE_FALL_LSB+1], edge_en[EDGE_RISE_LSB+1]};

  assign path_dis = stop_hw_disable_pin_i | {{2{|sw_dis[5:3]}}, {2{|sw_dis[2:0]}}};

  always_comb begin
    for (int p = 0; p < 4; p++) begin
      stop_acc[p] = inputs_open && diff_input_power_enable_o && stop_edge[p]
                    && path_en[p] && !path_dis[p] && stop_window
                    && (holdoff[p] == '0) && !over_range;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int p = 0; p < 4; p++) begin
      if (!rst_b_i || mrst) begin
        holdoff[p] <= '0;
      end else if (stop_acc[p]) begin
        holdoff[p] <= pair_holdoff(edge_delay_select);
      end else if (holdoff[p] != '0) begin
        holdoff[p] <= holdoff[p] - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop counters
  // Rising edge counters
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i || mrst) begin
      stop_hit_counter_a <= '0;
      stop_hit_counter_b <= '0;
    end else if (diff_input_power_enable_o) begin
      if (rise[1]) begin
        stop_hit_counter_a <= stop_hit_counter_a + 1'b1;
      end
      if (rise[2]) begin
        stop_hit_counter_b <= stop_hit_counter_b + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffers
  // Offset added to interval
  assign result_word = RESULT_W'(time_cnt) + RESULT_W'(start_offset);
  assign push        = {stop_acc[2] || stop_acc[3], stop_acc[0] || stop_acc[1]};
  assign pop[0]      = rd_en && (int'(reg_idx) == REG_IDX_RESULT_A);
  assign pop[1]      = rd_en && (int'(reg_idx) == REG_IDX_RESULT_B);

  for (genvar c = 0; c < 2; c++) begin : g_buf
    tscg_hit_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (HIT_DEPTH_P)
    ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .clear_i     (mrst),
      .push_i      (push[c]),
      .push_data_i (result_word),
      .pop_i       (pop[c]),
      .head_o      (head[c]),
      .empty_o     (fifo_empty[c]),
      .full_o      (fifo_full[c])
    );
  end

  assign result_buffer_empty_flag_o = fifo_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Result words and status
  always_ff @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= '0;
    end else if (rd_en) begin
      unique case (int'(reg_idx))
        REG_IDX_EDGE_EN:  avs_readdata_o <= 32'(edge_en);
        REG_IDX_SW_DIS:   avs_readdata_o <= 32'(sw_dis);
        REG_IDX_CMD:      avs_readdata_o <= 32'(edge_delay_select);
        REG_IDX_GATE:     avs_readdata_o <= 32'({start_close_after_first,
                                                 stop_gate_until_start, start_offset});
        REG_IDX_POWER:    avs_readdata_o <= 32'(diff_input_power_enable_o);
        REG_IDX_RESULT_A: avs_readdata_o <= fifo_empty[0] ? '0 : 32'(head[0]);
        REG_IDX_RESULT_B: avs_readdata_o <= fifo_empty[1] ? '0 : 32'(head[1]);
        REG_IDX_STATUS:   avs_readdata_o <= 32'({fifo_full, inputs_open, over_range,
                                                 start_seen, fifo_empty});
        REG_IDX_COUNTERS: avs_readdata_o <= 32'({stop_hit_counter_b, stop_hit_counter_a});
        default:          avs_readdata_o <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_stop_gate_hold: assert property (
    stop_gate_until_start && !start_seen |-> stop_acc == '0
  ) else $error("stop accepted before start while gated");

  a_start_close: assert property (
    start_close_after_first && start_seen |-> !start_acc
  ) else $error("second start accepted while closed");

  a_power_gate: assert property (
    !diff_input_power_enable_o |-> !start_acc && stop_acc == '0
  ) else $error("input accepted while unpowered");

  a_hw_disable: assert property (
    stop_hw_disable_pin_i[0] && stop_input_one_i && !$past(stop_input_one_i)
    |-> !stop_acc[0]
  ) else $error("rising edge passed hardware disable");

  a_sw_disable: assert property (
    (|sw_dis[5:3]) |-> !stop_acc[2] && !stop_acc[3]
  ) else $error("stop two passed software disable");

  a_counter_step: assert property (
    rise[1] && diff_input_power_enable_o && !mrst
    |=> stop_hit_counter_a == $past(stop_hit_counter_a) + 8'h01
  ) else $error("stop counter did not step");

  a_master_clear: assert property (
    mrst |=> stop_hit_counter_a == '0 && stop_hit_counter_b == '0 && fifo_empty == 2'h3
  ) else $error("master reset did not clear");

  a_rearm_delay: assert property (
    mrst ##1 !mrst ##1 !mrst |=> !$past(inputs_open) && inputs_open
  ) else $error("re-arm delay wrong");

  a_result_valid: assert property (
    push[0] && !mrst |-> ##[1:5] !result_buffer_empty_flag_o[0]
  ) else $error("result not valid in time");

  a_range_limit: assert property (
    over_range |-> stop_acc == '0 ##1 time_cnt == $past(time_cnt) || $past(start_acc)
                                      || $past(mrst)
  ) else $error("interval timer passed range");

  c_gated_capture: cover property (
    stop_gate_until_start && start_acc ##[1:4] stop_acc[0]
  );
  c_buffer_full: cover property (fifo_full[0]);
  c_master_reset: cover property (mrst ##[1:8] start_acc);

endmodule

// ==== dv/tscg_host.sv ====
// Host controller model driving the register bus
module tscg_host
  import tscg_pkg::*;
(
  input  wire logic                        ref_clk_i,
  output logic      [tscg_pkg::ADDR_W-1:0] avs_address_o,
  output logic                             avs_read_o,
  output logic                             avs_write_o,
  output logic      [tscg_pkg::DATA_W-1:0] avs_writedata_o,
  output logic      [3:0]                  avs_byteenable_o,
  input  wire logic [tscg_pkg::DATA_W-1:0] avs_readdata_i,
  input  wire logic                        avs_waitrequest_i,
  input  wire logic [1:0]                  result_buffer_empty_flag_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    avs_address_o = '0;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_writedata_o = '0;
    avs_byteenable_o = 4'h0;
  end
  // One access, entered just after a rising edge
  task automatic acc(input logic w, input int idx, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    avs_address_o <= ADDR_W'(idx * 4);
    avs_read_o <= ~w;
    avs_write_o <= w;
    avs_writedata_o <= d;
    avs_byteenable_o <= be;
    do @(posedge ref_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic wreg(input int idx, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    acc(1'b1, idx, d, be, q);
  endtask
  task automatic rreg(input int idx, output logic [31:0] q);
    acc(1'b0, idx, '0, 4'hF, q);
  endtask
  task automatic pop(input int ch, output logic [31:0] q);
    q = 32'hFFFF_FFFF;
    if (result_buffer_empty_flag_i[ch] === 1'b0) begin
      rreg(REG_IDX_RESULT_A + ch, q);
    end
  endtask
endmodule

// ==== dv/two_channel_stop_capture_gating_test.sv ====
// Self-checking bench for the stop capture and gating block
module two_channel_stop_capture_gating_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tscg_pkg::*;
  logic              ref_clk_i;
  logic              rst_b_i;
  logic [ADDR_W-1:0] adr;
  logic              rd;
  logic              wr;
  logic [31:0]       wd;
  logic [31:0]       rdat;
  logic [3:0]        be;
  logic              wreq;
  logic [2:0]        pin;
  logic              sdis;
  logic [3:0]        hdis;
  logic [1:0]        ef;
  logic              pwr;
  logic [31:0]       q;
  int                errors;
  int                check_count;
  int                off;
  int                k;
  int                na;
  int                nb;
  tscg_stop_capture u_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .start_i(pin[0]), .stop_input_one_i(pin[1]), .stop_input_two_i(pin[2]),
    .start_hw_disable_i(sdis), .stop_hw_disable_pin_i(hdis),
    .result_buffer_empty_flag_o(ef), .diff_input_power_enable_o(pwr)
  );
  tscg_host u_host (
    .ref_clk_i(ref_clk_i), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wd), .avs_byteenable_o(be),
    .avs_readdata_i(rdat), .avs_waitrequest_i(wreq),
    .result_buffer_empty_flag_i(ef)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] exp_res(int o, int d);
    return 32'(o + d);
  endfunction
  function automatic logic [31:0] exp_cnt(int a, int b);
    return {16'h0000, 8'(b), 8'(a)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic hit(input int ch);
    pin[ch] <= 1'b1;
    step(1);
    pin[ch] <= 1'b0;
    step(3);
  endtask
  task automatic mreset();
    u_host.wreg(REG_IDX_CMD, 32'h0040_0000, 4'h4);
    step(2);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    results();
  end
  initial begin
    errors = 0;
    check_count = 0;
    rst_b_i = 1'b0;
    pin = 3'b000;
    sdis = 1'b0;
    hdis = 4'h0;
    void'($urandom(87));
    step(12);
    rst_b_i <= 1'b1;
    step(2);
    chk(32'(ef), 32'h3);
    chk(32'(pwr), 32'h0);
    u_host.rreg(REG_IDX_EDGE_EN, q);
    chk(q, 32'h3F);
    u_host.rreg(15, q);
    chk(q, 32'h0);
    $display("test reset finished");
    u_host.wreg(REG_IDX_POWER, 32'h1, 4'hF);
    step(1);
    chk(32'(pwr), 32'h1);
    off = $urandom_range(1000, 0);
    u_host.wreg(REG_IDX_EDGE_EN, 32'h07, 4'hF);
    u_host.wreg(REG_IDX_GATE, 32'(off), 4'hF);
    hit(1);
    u_host.pop(0, q);
    chk(q, exp_res(off, 0));
    k = $urandom_range(20, 2);
    pin[0] <= 1'b1;
    step(k);
    pin[2] <= 1'b1;
    step(1);
    pin <= 3'b000;
    step(3);
    u_host.pop(1, q);
    chk(q, exp_res(off, k - 1));
    $display("test capture finished");
    mreset();
    na = $urandom_range(20, 1);
    nb = $urandom_range(20, 1);
    repeat (na) hit(1);
    repeat (nb) hit(2);
    u_host.rreg(REG_IDX_COUNTERS, q);
    chk(q, exp_cnt(na, nb));
    mreset();
    u_host.rreg(REG_IDX_COUNTERS, q);
    chk(q, 32'h0);
    chk(32'(ef), 32'h3);
    $display("test counters finished");
    hdis <= 4'h1;
    hit(1);
    chk(32'(ef), 32'h3);
    hdis <= 4'h0;
    u_host.wreg(REG_IDX_SW_DIS, 32'h38, 4'hF);
    hit(2);
    hit(1);
    chk(32'(ef), 32'h2);
    u_host.wreg(REG_IDX_SW_DIS, 32'h0, 4'hF);
    mreset();
    u_host.wreg(REG_IDX_EDGE_EN, 32'h05, 4'hF);
    hit(1);
    hit(2);
    chk(32'(ef), 32'h1);
    u_host.wreg(REG_IDX_EDGE_EN, 32'h07, 4'hF);
    mreset();
    $display("test disables finished");
    u_host.wreg(REG_IDX_GATE, 32'(off) | 32'h0004_0000, 4'hF);
    hit(1);
    sdis <= 1'b1;
    hit(0);
    hit(1);
    chk(32'(ef), 32'h3);
    sdis <= 1'b0;
    hit(0);
    hit(1);
    chk(32'(ef), 32'h2);
    mreset();
    $display("test gating finished");
    u_host.wreg(REG_IDX_GATE, 32'(off), 4'hF);
    repeat (HIT_DEPTH + 1) hit(1);
    for (int i = 0; i < HIT_DEPTH; i++) begin
      u_host.pop(0, q);
      chk(q, exp_res(off, 0));
    end
    step(1);
    chk(32'(ef), 32'h3);
    $display("test fill finished");
    mreset();
    u_host.wreg(REG_IDX_CMD, 32'h3, 4'h1);
    u_host.rreg(REG_IDX_CMD, q);
    chk(q, 32'h3);
    u_host.wreg(REG_IDX_GATE, 32'(off) | 32'h0008_0000, 4'hF);
    hit(0);
    hit(0);
    hit(1);
    u_host.pop(0, q);
    chk(q, exp_res(off, 7));
    step(2000);
    hit(1);
    chk(32'(ef), 32'h3);
    $display("test start close finished");
    results();
  end
endmodule
